// [common/term_map.vh]
// term_map.vh: register offsets, field positions, reset values and timing
// counts for the terminal escape sequence interpreter.
// assumes it is included by bare name from each design file that needs it.
`ifndef TERM_MAP_VH
`define TERM_MAP_VH

// ************************************************************
// register byte offsets (one aligned 32-bit word each)
// ************************************************************
`define OFF_CHAR_IN    8'h00
`define OFF_MODE       8'h04
`define OFF_CURSOR     8'h08
`define OFF_MARGINS    8'h0C
`define OFF_SAVED      8'h10
`define OFF_ERASE      8'h14
`define OFF_TEST       8'h18
`define OFF_REPLY      8'h1C
`define OFF_CTRL       8'h20
`define OFF_SCROLL     8'h24
`define OFF_LINE_WIDE  8'h28
`define OFF_TAB_QUERY  8'h2C

// ************************************************************
// field positions
// ************************************************************
`define MODE_SMOOTH    0
`define MODE_REVERSE   1
`define MODE_ORIGIN    2
`define MODE_UNSOL     3
`define CTRL_FAULT     0
`define CTRL_REND_LSB  4
`define CTRL_CSET_LSB  8
`define VALID_BIT      31

// ************************************************************
// screen geometry and reset values
// ************************************************************
`define ROWS           5'd24
`define LAST_ROW       5'd23
`define COLS           7'd80
`define LAST_COL       7'd79
`define PARAM_MAX      8'hFF

// ************************************************************
// reply kinds
// ************************************************************
`define REPLY_STATUS   2'd1
`define REPLY_CPR      2'd2
`define REPLY_PARAM    2'd3

// ************************************************************
// timing: smooth scroll ceiling
// ************************************************************
`define CLK_HZ         125000000
`define SMOOTH_LPS     6
`define SMOOTH_CYC     ((`CLK_HZ + `SMOOTH_LPS - 1) / `SMOOTH_LPS)

`endif

// [design/param_acc.v]
// param_acc.v: one decimal parameter accumulator of a control sequence.
// assumes digits arrive one per cycle as binary 0..9 from the parser.
`timescale 1ns/1ps
module param_acc (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // control from the parser
    input  wire       clr,
    input  wire       dig_en,
    input  wire [3:0] dig,
    // accumulated value
    output reg  [7:0] val_r
);
`include "term_map.vh"

    wire [11:0] prod;   // value times ten plus the digit
    assign prod = {4'h0, val_r} * 12'h00A + {8'h00, dig};

    // accumulate, saturating so oversize numbers stay large
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_r <= 8'h00;
        end else if (clr) begin
            val_r <= 8'h00;
        end else if (dig_en) begin
            val_r <= (prod > 12'h0FF) ? `PARAM_MAX : prod[7:0];
        end
    end
endmodule

// [design/tab_mem.v]
// tab_mem.v: one bit of tab stop per column, registered read port.
// assumes column numbers below 80 from the interpreter.
`timescale 1ns/1ps
module tab_mem (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // write port
    input  wire       set_en,
    input  wire [6:0] set_col,
    // read port
    input  wire [6:0] rd_col,
    output reg        rd_bit_r
);
    reg [79:0] stop_r;   // one flag per column

    // set a stop; read out through a flip-flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_r   <= 80'h0;
            rd_bit_r <= 1'b0;
        end else begin
            if (set_en) begin
                stop_r[set_col] <= 1'b1;
            end
            rd_bit_r <= (rd_col < 7'd80) ? stop_r[rd_col] : 1'b0;
        end
    end
endmodule

// [design/seq_interp.v]
// seq_interp.v: escape and control sequence interpreter with an apb slave.
// assumes software feeds received characters through the char register,
// and the display engine reads cursor, margins, erase and scroll state.
//
// Summary of operation
// - parameter request answered with parameter report
// - no unsolicited reports after reset
// - ESC 7 saves cursor, rendition, charset
// - jump scroll or smooth, six lines/sec max
// - reverse screen setting selects black on white
// - margin sequence sets top and bottom lines
// - region at least two lines high
// - cursor homes after margins set
// - ESC # 5 makes line single width
// - confidence test runs summed tests, zero resets
// - weights 1,2,4 select tests, 8 repeats
// - status request 5 answers 0 or 3
// - status request 6 answers cursor position
// - erase in display, parameter 0/1/2
// - erased lines single width, cursor stays
// - erase in line, parameter 0/1/2
// - ESC H sets tab at cursor column
// - absolute position line then column, zero=one
// - positioning honours origin setting like cursor position
// - ESC D moves down or scrolls region
// - modes change by set/reset sequences; zero-weight test clears them, parameter request sets unsolicited
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "term_map.vh"
module seq_interp #(
    parameter [31:0] SMOOTH_CYC = `SMOOTH_CYC
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr
);

    // ************************************************************
    // parser states
    // ************************************************************
    localparam [1:0] ST_GROUND = 2'd0;
    localparam [1:0] ST_ESC    = 2'd1;
    localparam [1:0] ST_CSI    = 2'd2;
    localparam [1:0] ST_HASH   = 2'd3;

    reg  [1:0]  state_r;        // parser state
    reg         pidx_r;         // which parameter digits go to
    reg  [1:0]  npar_r;         // parameters seen, up to two
    reg         priv_r;         // private marker seen
    reg         smooth_r;       // smooth scroll setting
    reg         reverse_r;      // reverse screen setting
    reg         origin_r;       // origin setting
    reg         unsol_r;        // unsolicited reports allowed
    reg  [4:0]  row_r;          // active line, 0 based
    reg  [6:0]  col_r;          // active column, 0 based
    reg  [4:0]  top_r;          // scroll region top
    reg  [4:0]  bot_r;          // scroll region bottom
    reg  [19:0] saved_r;        // row, col, rendition, charset
    reg  [31:0] erase_r;        // last erase command
    reg  [31:0] test_r;         // last test request
    reg  [31:0] reply_r;        // pending reply
    reg  [11:0] ctrl_r;         // fault, rendition, charset
    reg  [23:0] wide_r;         // per-line double width flags
    reg  [6:0]  tabq_r;         // tab query column
    reg         scr_pend_r;     // scroll waiting for pacing
    reg  [15:0] scr_cnt_r;      // scrolls performed
    reg  [31:0] pace_r;         // cycles left before next smooth scroll

    wire [7:0]  p1;             // first parameter
    wire [7:0]  p2;             // second parameter
    wire        tab_bit;        // tab stop at queried column

    // ************************************************************
    // apb decode
    // ************************************************************
    wire setup   = psel & ~pready;
    wire done    = psel & penable & pready;
    wire is_char = (paddr == `OFF_CHAR_IN);
    wire ch_go   = done & pwrite & is_char;
    wire [7:0] ch = pwdata[7:0];
    wire rd_rep  = done & ~pwrite & (paddr == `OFF_REPLY);
    wire rd_era  = done & ~pwrite & (paddr == `OFF_ERASE);

    wire is_dig  = (ch >= 8'h30) && (ch <= 8'h39);
    wire in_csi  = ch_go && (state_r == ST_CSI);
    wire dig_go  = in_csi && is_dig;
    wire fin     = in_csi && (ch >= 8'h40) && (ch <= 8'h7E);
    wire esc_go  = ch_go && (state_r == ST_ESC);

    // ************************************************************
    // parameter accumulators
    // ************************************************************
    wire pclr = ch_go && (state_r == ST_ESC) && (ch == 8'h5B);

    param_acc u_p1 (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (pclr),
        .dig_en  (dig_go && !pidx_r),
        .dig     (ch[3:0]),
        .val_r   (p1)
    );

    param_acc u_p2 (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (pclr),
        .dig_en  (dig_go && pidx_r),
        .dig     (ch[3:0]),
        .val_r   (p2)
    );

    tab_mem u_tabs (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_en   (esc_go && (ch == 8'h48)),
        .set_col  (col_r),
        .rd_col   (tabq_r),
        .rd_bit_r (tab_bit)
    );

    // ************************************************************
    // derived positions
    // ************************************************************
    wire [4:0] home_row = origin_r ? top_r : 5'd0;
    wire [4:0] lim_row  = origin_r ? bot_r : `LAST_ROW;
    wire [7:0] pl       = (p1 == 8'h00) ? 8'h00 : p1 - 8'h01;
    wire [7:0] pc       = (p2 == 8'h00) ? 8'h00 : p2 - 8'h01;
    wire [8:0] tgt_row  = {1'b0, pl} + {4'h0, home_row};
    wire [4:0] new_row  = (npar_r == 2'd0) ? home_row :
                          (tgt_row > {4'h0, lim_row}) ? lim_row : tgt_row[4:0];
    wire [6:0] new_col  = (npar_r < 2'd2) ? 7'd0 :
                          (pc > {1'b0, `LAST_COL}) ? `LAST_COL : pc[6:0];
    wire [4:0] rep_row  = row_r - home_row + 5'd1;
    wire [4:0] m_top    = (npar_r == 2'd0 || p1 == 8'h00) ? 5'd0 : pl[4:0];
    wire [4:0] m_bot    = (npar_r < 2'd2 || p2 == 8'h00) ? `LAST_ROW : pc[4:0];
    wire       m_ok     = (npar_r == 2'd0) ||
                          ((pc < {3'b000, `ROWS} || p2 == 8'h00) && (pl < {3'b000, `ROWS}) &&
                           (m_top < m_bot));
    wire [7:0] mode_p   = (npar_r == 2'd0) ? 8'h00 : p1;

    // ************************************************************
    // parser and terminal state
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_GROUND;
            pidx_r    <= 1'b0;
            npar_r    <= 2'd0;
            priv_r    <= 1'b0;
            smooth_r  <= 1'b0;
            reverse_r <= 1'b0;
            origin_r  <= 1'b0;
            unsol_r   <= 1'b0;
            row_r     <= 5'd0;
            col_r     <= 7'd0;
            top_r     <= 5'd0;
            bot_r     <= `LAST_ROW;
            saved_r   <= 20'h0;
            erase_r   <= 32'h0;
            test_r    <= 32'h0;
            reply_r   <= 32'h0;
            wide_r    <= 24'h0;
            scr_pend_r <= 1'b0;
        end else begin
            // clear-on-read first so a new event in the same cycle wins
            if (rd_rep) begin
                reply_r[`VALID_BIT] <= 1'b0;
            end
            if (rd_era) begin
                erase_r[`VALID_BIT] <= 1'b0;
            end
            if (scr_pend_r && (!smooth_r || pace_r == 32'h0)) begin
                scr_pend_r <= 1'b0;
            end
            if (ch_go) begin
                case (state_r)
                    ST_GROUND: begin
                        if (ch == 8'h1B) begin
                            state_r <= ST_ESC;
                        end
                    end
                    ST_ESC: begin
                        state_r <= ST_GROUND;
                        pidx_r  <= 1'b0;
                        npar_r  <= 2'd0;
                        priv_r  <= 1'b0;
                        if (ch == 8'h5B) begin
                            state_r <= ST_CSI;
                        end else if (ch == 8'h23) begin
                            state_r <= ST_HASH;
                        end else if (ch == 8'h37) begin
                            // save cursor, rendition, charset
                            saved_r <= {row_r, col_r, ctrl_r[11:4]};
                        end else if (ch == 8'h44) begin
                            // index: move down, or scroll at the bottom margin
                            if (row_r == bot_r) begin
                                scr_pend_r <= 1'b1;
                            end else if (row_r < `LAST_ROW) begin
                                row_r <= row_r + 5'd1;
                            end
                        end
                    end
                    ST_HASH: begin
                        state_r <= ST_GROUND;
                        if (ch == 8'h35) begin
                            wide_r[row_r] <= 1'b0;
                        end
                    end
                    default: begin
                        // inside a control sequence
                        if (is_dig) begin
                            if (npar_r == 2'd0) begin
                                npar_r <= 2'd1;
                            end
                        end else if (ch == 8'h3B) begin
                            pidx_r <= 1'b1;
                            npar_r <= 2'd2;
                        end else if (ch == 8'h3F) begin
                            priv_r <= 1'b1;
                        end else if (fin) begin
                            state_r <= ST_GROUND;
                            if (ch == 8'h78 && p1 < 8'h02) begin
                                // parameter request: solicit 0 allows unsolicited
                                unsol_r <= (p1 == 8'h00);
                                reply_r <= {1'b1, 21'h0, `REPLY_PARAM, p1 + 8'h02};
                            end else if (ch == 8'h6E && p1 == 8'h05) begin
                                reply_r <= {1'b1, 21'h0, `REPLY_STATUS,
                                            ctrl_r[`CTRL_FAULT] ? 8'h03 : 8'h00};
                            end else if (ch == 8'h6E && p1 == 8'h06) begin
                                reply_r <= {1'b1, 10'h0, rep_row, 6'h0, `REPLY_CPR,
                                            1'b0, col_r + 7'd1};
                            end else if (ch == 8'h72 && m_ok) begin
                                top_r <= m_top;
                                bot_r <= m_bot;
                                row_r <= origin_r ? m_top : 5'd0;
                                col_r <= 7'd0;
                            end else if (ch == 8'h66 || ch == 8'h48) begin
                                row_r <= new_row;
                                col_r <= new_col;
                            end else if ((ch == 8'h68 || ch == 8'h6C) && priv_r) begin
                                // set or clear a private mode; others ignored
                                if (mode_p == 8'h04) begin
                                    smooth_r <= (ch == 8'h68);
                                end else if (mode_p == 8'h05) begin
                                    reverse_r <= (ch == 8'h68);
                                end else if (mode_p == 8'h06) begin
                                    origin_r <= (ch == 8'h68);
                                    row_r    <= (ch == 8'h68) ? top_r : 5'd0;
                                    col_r    <= 7'd0;
                                end
                            end else if (ch == 8'h79 && p1 == 8'h02 && p2 < 8'h10) begin
                                if (p2 == 8'h00) begin
                                    // zero weight: reset only
                                    smooth_r  <= 1'b0;
                                    reverse_r <= 1'b0;
                                    origin_r  <= 1'b0;
                                    unsol_r   <= 1'b0;
                                    top_r     <= 5'd0;
                                    bot_r     <= `LAST_ROW;
                                    row_r     <= 5'd0;
                                    col_r     <= 7'd0;
                                    wide_r    <= 24'h0;
                                    test_r    <= {1'b1, 1'b1, 26'h0, 4'h0};
                                end else begin
                                    test_r <= {1'b1, 1'b0, 26'h0, p2[3:0]};
                                end
                            end else if ((ch == 8'h4A || ch == 8'h4B) &&
                                         (npar_r == 2'd0 || p1 < 8'h03)) begin
                                erase_r <= {1'b1, 9'h0, (ch == 8'h4A), mode_p[1:0],
                                            row_r, 7'h0, col_r};
                                if (ch == 8'h4A) begin
                                    // fully erased lines drop double width
                                    if (mode_p == 8'h02) begin
                                        wide_r <= 24'h0;
                                    end else if (mode_p == 8'h01) begin
                                        wide_r <= wide_r & ~((24'h00_0001 << row_r) - 24'h00_0001);
                                    end else begin
                                        wide_r <= wide_r & ((24'h00_0002 << row_r) - 24'h00_0001);
                                    end
                                end
                            end
                        end else begin
                            state_r <= ST_GROUND;   // unexpected byte aborts
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // smooth scroll pacing and scroll counter
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace_r    <= 32'h0;
            scr_cnt_r <= 16'h0;
        end else if (scr_pend_r && (!smooth_r || pace_r == 32'h0)) begin
            scr_cnt_r <= scr_cnt_r + 16'h1;
            pace_r    <= smooth_r ? SMOOTH_CYC - 32'h1 : 32'h0;
        end else if (pace_r != 32'h0) begin
            pace_r <= pace_r - 32'h1;
        end
    end

    // ************************************************************
    // software written registers
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 12'h0;
            tabq_r <= 7'd0;
        end else if (done && pwrite) begin
            if (paddr == `OFF_CTRL) begin
                ctrl_r <= pwdata[11:0];
            end else if (paddr == `OFF_TAB_QUERY) begin
                tabq_r <= pwdata[6:0];
            end
        end
    end

    // line width flags are not software writable; a write to OFF_LINE_WIDE is refused
    // so the interpreter alone clears them
    // ************************************************************
    // apb response
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (setup && !(is_char && pwrite && scr_pend_r)) begin
            // answer one cycle after setup; stall chars while a scroll waits
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (!pwrite) begin
                if (paddr == `OFF_MODE) begin
                    prdata <= {28'h0, unsol_r, origin_r, reverse_r, smooth_r};
                end else if (paddr == `OFF_CURSOR) begin
                    prdata <= {11'h0, row_r, 9'h0, col_r};
                end else if (paddr == `OFF_MARGINS) begin
                    prdata <= {11'h0, bot_r, 11'h0, top_r};
                end else if (paddr == `OFF_SAVED) begin
                    prdata <= {12'h0, saved_r};
                end else if (paddr == `OFF_ERASE) begin
                    prdata <= erase_r;
                end else if (paddr == `OFF_TEST) begin
                    prdata <= test_r;
                end else if (paddr == `OFF_REPLY) begin
                    prdata <= reply_r;
                end else if (paddr == `OFF_CTRL) begin
                    prdata <= {20'h0, ctrl_r};
                end else if (paddr == `OFF_SCROLL) begin
                    prdata <= {15'h0, scr_pend_r, scr_cnt_r};
                end else if (paddr == `OFF_LINE_WIDE) begin
                    prdata <= {8'h0, wide_r};
                end else if (paddr == `OFF_TAB_QUERY) begin
                    prdata <= {24'h0, tab_bit, tabq_r};
                end else if (paddr != `OFF_CHAR_IN) begin
                    pslverr <= 1'b1;
                end
            end else if (!(is_char || paddr == `OFF_CTRL || paddr == `OFF_TAB_QUERY)) begin
                pslverr <= 1'b1;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

// [bench/seq_interp_monitor.sv]
// seq_interp_monitor.sv: apb timing and refusal checks on the interpreter.
// assumes it is bound to seq_interp and sees only its ports.
`timescale 1ns/1ps
module seq_interp_monitor #(
    parameter [31:0] SMOOTH_CYC = 20
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable; // setup phase of a transfer
    ready_once_a: assert property (pready |=> !pready) else $error("pready held");
    ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
    err_pair_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    idle_quiet_a: assert property (!psel |=> !pready) else $error("unsolicited answer");
    unmapped_err_a: assert property (setup && paddr > 8'h2C |=> pready && pslverr) else $error("no error");
    mapped_ok_a: assert property (setup && !pwrite && paddr != 8'h00 && paddr <= 8'h2C |=> pready && !pslverr)
        else $error("bad read answer");
    mode_ro_a: assert property (setup && pwrite && paddr == 8'h04 |=> pready && pslverr)
        else $error("mode written");
    char_done_a: assert property (setup && pwrite && paddr == 8'h00 |-> ##[1:1000] pready)
        else $error("char hung");
    cover property (pready && pslverr);
    cover property (setup && pwrite && paddr == 8'h00);
    cover property (pready && !pwrite && paddr == 8'h1C);
endmodule
bind seq_interp seq_interp_monitor #(.SMOOTH_CYC(SMOOTH_CYC)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// [bench/host_apb.sv]
// host_apb.sv: host model, sends characters and register traffic over apb.
// assumes the bench makes pclk and calls tasks just after a rising edge.
`timescale 1ns/1ps
module host_apb (
    input  wire         pclk,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [7:0]  paddr,
    output logic [31:0] pwdata,
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr
);
    int to_n = 0; // waits that ran out
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    end
    // one transfer: request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 2000);
        if (n >= 2000) to_n++;
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // one character per write, low byte
    task automatic send(input string s);
        logic [31:0] q; logic e;
        foreach (s[i]) xfer(1, 8'h00, {24'h0, s[i]}, q, e);
    endtask
endmodule

// [bench/tb_terminal_escape_sequence_interpreter.sv]
// tb_terminal_escape_sequence_interpreter.sv: self-checking bench.
// assumes seq_interp with a short smooth scroll count.
`timescale 1ns/1ps
module tb_terminal_escape_sequence_interpreter;
    logic pclk = 0, presetn = 0;
    wire psel, penable, pwrite, pready, pslverr;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    int mismatches = 0, checks = 0, row, col, scr; // model position, 1 based
    logic [15:0] lf = 16'd77; // random source
    logic [31:0] q;
    logic e;
    always #4 pclk = ~pclk;
    host_apb host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    seq_interp #(.SMOOTH_CYC(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // read a register and compare
    task automatic chk(input logic [7:0] a, input logic [31:0] x, input string nm);
        host.xfer(0, a, 0, q, e);
        checks++;
        if (q !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, x, q);
        end
    endtask
    task automatic summarize;
        mismatches += host.to_n;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(8'h04, 32'h0000_0000, "mode");
        chk(8'h0C, 32'h0017_0000, "margins");
        host.send("\033[?4h\033[?5h");
        host.xfer(1, 8'h04, 32'h0000_0000, q, e);
        chk(8'h04, 32'h0000_0003, "mode");
        host.send("\033[?4l");
        chk(8'h04, 32'h0000_0002, "mode");
        host.send("\033[0;0f");
        chk(8'h08, 32'h0000_0000, "cursor");
        repeat (4) begin
            lf = nxt(lf); row = lf % 24 + 1; lf = nxt(lf); col = lf % 80 + 1;
            host.send($sformatf("\033[%0d;%0df", row, col));
            chk(8'h08, {11'h0, 5'(row - 1), 9'h0, 7'(col - 1)}, "cursor");
        end
        host.send("\033D\033H");
        scr = (row == 24); // index at the bottom margin scrolls
        row = (row < 24) ? row + 1 : row;
        chk(8'h08, {11'h0, 5'(row - 1), 9'h0, 7'(col - 1)}, "index");
        host.xfer(1, 8'h2C, {25'h0, 7'(col - 1)}, q, e);
        chk(8'h2C, {24'h0, 1'b1, 7'(col - 1)}, "tab");
        host.send("\033[5;10r");
        chk(8'h0C, 32'h0009_0004, "margins");
        chk(8'h08, 32'h0000_0000, "home");
        host.send("\033[9;9r");
        chk(8'h0C, 32'h0009_0004, "margins");
        host.send("\033[3;4f\033[2J");
        chk(8'h14, 32'h8030_8003, "erase");
        chk(8'h08, 32'h0002_0003, "cursor");
        host.send("\033[1K");
        chk(8'h14, 32'h8008_8003, "erase");
        host.send("\033[5n");
        chk(8'h1C, 32'h8000_0100, "status");
        host.xfer(1, 8'h20, 32'h0000_0001, q, e);
        host.send("\033[5n");
        chk(8'h1C, 32'h8000_0103, "status");
        host.send("\033[1x");
        chk(8'h1C, 32'h8000_0303, "report");
        host.send("\033[2;9y");
        chk(8'h18, 32'h8000_0009, "test");
        host.send("\033[?6h\033[2;3f\033[6n");
        chk(8'h1C, 32'h8002_0203, "cpr");
        host.xfer(1, 8'h20, 32'h0000_0A51, q, e);
        host.send("\0337");
        chk(8'h10, 32'h0002_82A5, "saved");
        host.send("\033[?4h\033[10;1f\033D\033DA");
        chk(8'h24, {16'h0, 16'(scr + 2)}, "scroll");
        host.send("\033[2;0y");
        chk(8'h18, 32'hC000_0000, "test");
        chk(8'h04, 32'h0000_0000, "mode");
        host.xfer(0, 8'h40, 0, q, e);
        checks++;
        if (e !== 1'b1) begin
            mismatches++;
            $display("[FAIL] pslverr expected 1 seen %b", e);
        end
        summarize();
    end
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
endmodule
